//--- verilog/sio_term_map.vh
// register offsets, function codes, reset values and timing counts for the terminal mapper
`ifndef SIO_TERM_MAP_VH
`define SIO_TERM_MAP_VH
`define SIO_A_IN_FUNC0 12'h000
`define SIO_A_POS_LO 12'h018
`define SIO_A_POS_HI 12'h01c
`define SIO_A_FORCE0 12'h020
`define SIO_A_OUT_FUNC0 12'h040
`define SIO_A_VIN_CTRL 12'h060
`define SIO_A_VIN_STATE 12'h064
`define SIO_A_VOUT_CTRL 12'h068
`define SIO_A_VOUT_STATE 12'h06c
`define SIO_A_VIN_FUNC0 12'h080
`define SIO_A_TRQ_LEVEL 12'h0a0
`define SIO_A_TRQ_HYST 12'h0a4
`define SIO_A_TRQ_POL 12'h0a8
`define SIO_A_ZSP_THR 12'h0ac
`define SIO_A_BRK_DLY 12'h0b0
`define SIO_A_ZPW 12'h0b4
`define SIO_A_SER_FUNC 12'h0b8
`define SIO_A_STATUS 12'h0bc
`define SIO_R_IN_FUNC {16'h0000, 16'h0000, 16'h0004, 16'h0003, 16'h0002, 16'h0001}
`define SIO_R_OUT_FUNC {16'h0012, 16'h0008, 16'h0005, 16'h0003, 16'h0002}
`define SIO_R_TRQ_LEVEL 16'h0064
`define SIO_R_TRQ_HYST 16'h0005
`define SIO_R_ZSP_THR 16'h0005
`define SIO_R_ZPW 16'h0032
`define SIO_ZSP_HYST 17'sd5
`define SIO_F_NULL 7'd0
`define SIO_F_ENABLE 7'd1
`define SIO_F_ALM_CLR 7'd2
`define SIO_F_TRQ_ARR 7'd5
`define SIO_F_ZSP 7'd8
`define SIO_F_BRK 7'd9
`define SIO_F_INDEX 7'd18
`define SIO_CLK_MHZ 250
`define SIO_MS_US 1000
`define SIO_MS_CYC (`SIO_CLK_MHZ * `SIO_MS_US)
`define SIO_US_CYC `SIO_CLK_MHZ
`endif

//--- verilog/sio_term_mapper.v
// servo terminal mapper: input function decode, status outputs, apb registers
`timescale 1ns/1ps
`include "sio_term_map.vh"
module sio_term_mapper #(
  parameter MS_CYCLES = `SIO_MS_CYC, // cycles per millisecond
  parameter US_CYCLES = `SIO_US_CYC // cycles per microsecond
) (
  input wire pclk, // apb clock, 250 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready, always high
  output reg [31:0] prdata, // apb read data
  output reg pslverr, // unmapped access
  input wire [3:0] phys_input_n, // input terminals, active low
  input wire signed [15:0] motor_torque, // measured torque, percent
  input wire signed [15:0] motor_speed, // measured speed, r/min
  input wire index_event, // encoder index pulse, one cycle
  input wire [31:0] position_count, // current position
  output reg [3:0] phys_output, // output terminals 1-4
  output reg phys_output_5, // fifth output / differential line
  output reg serial_port_enable, // serial port active
  output reg drive_enable_in, // decoded enable function
  output reg alarm_clear_in, // alarm clear pulse
  output reg torque_arrival_out, // status: torque arrival
  output reg zero_speed_out, // status: zero speed
  output reg brake_release_out, // status: brake release
  output reg index_out // index pulse output
);
  reg [15:0] in_func_q [0:5];
  reg [15:0] out_func_q [0:4];
  reg [15:0] force_q [0:4];
  reg [15:0] vin_func_q [0:7];
  reg [1:0] vin_ctrl_q;
  reg [7:0] vin_state_q;
  reg vout_ctrl_q;
  reg [3:0] vout_state_q;
  reg [15:0] trq_level_q, trq_hyst_q, zsp_thr_q, brk_dly_q, zpw_q;
  reg trq_pol_q, ser_func_q;
  reg [3:0] in_s1_q, in_s2_q;
  reg [11:0] act_q;
  reg enable_q, alarm_clr_q;
  reg [27:0] brk_cnt_q;
  reg [15:0] ms_cnt_q;
  reg [7:0] zp_cnt_q;
  reg [7:0] us_cnt_q;
  wire [11:0] act_d;
  wire en_d, clr_d;
  wire apb_wr = psel & penable & pwrite;
  // one loop index per process, so no variable has two drivers
  integer i;
  integer i_dec;
  integer i_out;
  integer i_rd;

  function [6:0] code_of;
    input [15:0] v;
    begin
      code_of = (v > 16'd99) ? 7'd0 : v[6:0];
    end
  endfunction

  function out_sel;
    input [15:0] v;
    input ta, zs, br, ix, en;
    begin
      case (code_of(v))
        `SIO_F_TRQ_ARR: out_sel = ta;
        `SIO_F_ZSP: out_sel = zs;
        `SIO_F_BRK: out_sel = br;
        `SIO_F_INDEX: out_sel = ix;
        `SIO_F_ENABLE: out_sel = en;
        default: out_sel = 1'b0;
      endcase
    end
  endfunction

  // zero wait states: every register is a flop or a pin, nothing to wait for
  assign pready = 1'b1;

  // input terminals: invert then sync, forcing overrides the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q <= 4'h0;
      in_s2_q <= 4'h0;
    end else begin
      in_s1_q <= ~phys_input_n;
      in_s2_q <= in_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_phys
      assign act_d[g] = (vin_ctrl_q != 2'd1) & (in_s2_q[g] | force_q[0][g]);
    end
    for (g = 0; g < 8; g = g + 1) begin : g_virt
      assign act_d[4+g] = (vin_ctrl_q != 2'd0) & vin_state_q[g];
    end
  endgenerate

  // decode every active terminal through its own function code
  reg en_c, clr_c;
  always @* begin
    en_c = 1'b0;
    clr_c = 1'b0;
    for (i_dec = 0; i_dec < 4; i_dec = i_dec + 1) begin
      if (act_d[i_dec] && code_of(in_func_q[i_dec]) == `SIO_F_ENABLE) en_c = 1'b1;
      if (act_d[i_dec] && code_of(in_func_q[i_dec]) == `SIO_F_ALM_CLR) clr_c = 1'b1;
    end
    for (i_dec = 0; i_dec < 8; i_dec = i_dec + 1) begin
      if (act_d[4+i_dec] && code_of(vin_func_q[i_dec]) == `SIO_F_ENABLE) en_c = 1'b1;
      if (act_d[4+i_dec] && code_of(vin_func_q[i_dec]) == `SIO_F_ALM_CLR) clr_c = 1'b1;
    end
  end
  // code 0 never matches any function, so such a terminal is ignored
  assign en_d = en_c;
  assign clr_d = clr_c;

  wire signed [16:0] trq_lv = {1'b0, trq_level_q};
  wire signed [16:0] trq_hy = {1'b0, trq_hyst_q};
  wire signed [16:0] tq = {motor_torque[15], motor_torque};
  wire signed [16:0] tq_abs = tq[16] ? -tq : tq;
  // polarity 0: either direction; 1: positive torque only
  wire signed [16:0] tq_m = trq_pol_q ? tq : tq_abs;
  wire signed [16:0] sp = {motor_speed[15], motor_speed};
  wire signed [16:0] sp_abs = sp[16] ? -sp : sp;
  wire signed [16:0] zs_thr = {1'b0, zsp_thr_q};

  // decode stage is registered so the status word shows what was decoded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 12'h000;
      enable_q <= 1'b0;
      alarm_clr_q <= 1'b0;
      drive_enable_in <= 1'b0;
      alarm_clear_in <= 1'b0;
    end else begin
      act_q <= act_d;
      enable_q <= en_d;
      alarm_clr_q <= clr_d;
      drive_enable_in <= en_d;
      // only the inactive-to-active edge clears; a held terminal does nothing more
      alarm_clear_in <= clr_d & ~alarm_clr_q;
    end
  end

  // torque arrival: release band sits below the level so noise cannot chatter it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_arrival_out <= 1'b0;
    end else begin
      if (tq_m > trq_lv) begin
        torque_arrival_out <= 1'b1;
      end else if (tq_m <= trq_lv - trq_hy) begin
        torque_arrival_out <= 1'b0;
      end
    end
  end

  // zero speed: threshold is programmable, the release band is fixed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_speed_out <= 1'b0;
    end else begin
      if (sp_abs < zs_thr) begin
        zero_speed_out <= 1'b1;
      end else if (sp_abs >= zs_thr + `SIO_ZSP_HYST) begin
        zero_speed_out <= 1'b0;
      end
    end
  end

  // brake delay counted in whole milliseconds from enable
  // limitation: above 65535 cycles per ms every clock cycle counts as one whole ms
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_release_out <= 1'b0;
      brk_cnt_q <= 28'h0000000;
      ms_cnt_q <= 16'h0000;
    end else begin
      if (!en_d) begin
        brake_release_out <= 1'b0;
        brk_cnt_q <= 28'h0000000;
        ms_cnt_q <= 16'h0000;
      end else if (brk_cnt_q[15:0] >= brk_dly_q) begin
        brake_release_out <= 1'b1;
      end else if (ms_cnt_q == MS_CYCLES[15:0] - 16'd1 || MS_CYCLES > 65535) begin
        ms_cnt_q <= 16'h0000;
        brk_cnt_q <= brk_cnt_q + 28'd1;
      end else begin
        ms_cnt_q <= ms_cnt_q + 16'd1;
      end
    end
  end

  // index width counted in microseconds; a new event restarts the pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_out <= 1'b0;
      zp_cnt_q <= 8'h00;
      us_cnt_q <= 8'h00;
    end else begin
      if (index_event) begin
        index_out <= 1'b1;
        zp_cnt_q <= (zpw_q == 16'h0000) ? 8'd1 : zpw_q[7:0];
        us_cnt_q <= 8'h00;
      end else if (index_out) begin
        if (us_cnt_q == US_CYCLES[7:0] - 8'd1) begin
          us_cnt_q <= 8'h00;
          zp_cnt_q <= zp_cnt_q - 8'd1;
          if (zp_cnt_q <= 8'd1) begin
            index_out <= 1'b0;
          end
        end else begin
          us_cnt_q <= us_cnt_q + 8'd1;
        end
      end
    end
  end

  // output terminals follow the status flops one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_output <= 4'h0;
      phys_output_5 <= 1'b0;
      serial_port_enable <= 1'b1;
    end else begin
      for (i_out = 0; i_out < 4; i_out = i_out + 1) begin
        if (vout_ctrl_q) begin
          phys_output[i_out] <= vout_state_q[i_out];
        end else begin
          phys_output[i_out] <= out_sel(out_func_q[i_out], torque_arrival_out,
            zero_speed_out, brake_release_out, index_out, enable_q);
        end
      end
      serial_port_enable <= ~ser_func_q;
      // while the serial port owns the line the fifth output must stay quiet
      if (ser_func_q) begin
        phys_output_5 <= out_sel(out_func_q[4], torque_arrival_out,
          zero_speed_out, brake_release_out, index_out, enable_q);
      end else begin
        phys_output_5 <= 1'b0;
      end
    end
  end

  // apb register file; writes land in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 6; i = i + 1)
        in_func_q[i] <= 16'h0000;
      in_func_q[0] <= 16'h0001;
      in_func_q[1] <= 16'h0002;
      in_func_q[2] <= 16'h0003;
      in_func_q[3] <= 16'h0004;
      out_func_q[0] <= 16'h0002;
      out_func_q[1] <= 16'h0003;
      out_func_q[2] <= 16'h0005;
      out_func_q[3] <= 16'h0008;
      out_func_q[4] <= 16'h0012;
      for (i = 0; i < 5; i = i + 1)
        force_q[i] <= 16'h0000;
      for (i = 0; i < 8; i = i + 1)
        vin_func_q[i] <= 16'h0000;
      vin_ctrl_q <= 2'd0;
      vin_state_q <= 8'h00;
      vout_ctrl_q <= 1'b0;
      vout_state_q <= 4'h0;
      trq_level_q <= `SIO_R_TRQ_LEVEL;
      trq_hyst_q <= `SIO_R_TRQ_HYST;
      trq_pol_q <= 1'b0;
      zsp_thr_q <= `SIO_R_ZSP_THR;
      brk_dly_q <= 16'h0000;
      zpw_q <= `SIO_R_ZPW;
      ser_func_q <= 1'b0;
    end else if (apb_wr) begin
      for (i = 0; i < 6; i = i + 1)
        if (paddr == `SIO_A_IN_FUNC0 + 4 * i) in_func_q[i] <= pwdata[15:0];
      for (i = 0; i < 5; i = i + 1) begin
        if (paddr == `SIO_A_OUT_FUNC0 + 4 * i) out_func_q[i] <= pwdata[15:0];
        if (paddr == `SIO_A_FORCE0 + 4 * i) force_q[i] <= pwdata[15:0];
      end
      for (i = 0; i < 8; i = i + 1)
        if (paddr == `SIO_A_VIN_FUNC0 + 4 * i) vin_func_q[i] <= pwdata[15:0];
      // out-of-range values clamp to the top of the legal range rather than wrap
      // code 3 is not a mode, so it falls back to the widest one
      case (paddr)
        `SIO_A_VIN_CTRL: vin_ctrl_q <= (pwdata[1:0] == 2'd3) ? 2'd2 : pwdata[1:0];
        `SIO_A_VIN_STATE: vin_state_q <= pwdata[7:0];
        `SIO_A_VOUT_CTRL: vout_ctrl_q <= pwdata[0];
        `SIO_A_VOUT_STATE: vout_state_q <= pwdata[3:0];
        `SIO_A_TRQ_LEVEL: trq_level_q <= pwdata[15:0];
        `SIO_A_TRQ_HYST: trq_hyst_q <= pwdata[15:0];
        `SIO_A_TRQ_POL: trq_pol_q <= pwdata[0];
        `SIO_A_ZSP_THR: zsp_thr_q <= (pwdata[15:0] > 16'd1000) ? 16'd1000 : pwdata[15:0];
        `SIO_A_BRK_DLY: brk_dly_q <= (pwdata[15:0] > 16'd200) ? 16'd200 : pwdata[15:0];
        `SIO_A_ZPW: zpw_q <= (pwdata[15:0] > 16'd200) ? 16'd200 : pwdata[15:0];
        `SIO_A_SER_FUNC: ser_func_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // unaligned or unused addresses are refused with an error, never aliased
  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && ((a < 12'h018) || (a < 12'h034 && a >= 12'h018) ||
        (a >= 12'h040 && a < 12'h054) || (a >= 12'h060 && a < 12'h070) ||
        (a >= 12'h080 && a < 12'h0c0));
    end
  endfunction

  always @* begin
    prdata = 32'h00000000;
    pslverr = psel & penable & ~mapped(paddr);
    for (i_rd = 0; i_rd < 6; i_rd = i_rd + 1)
      if (paddr == `SIO_A_IN_FUNC0 + 4 * i_rd) prdata = {16'h0000, in_func_q[i_rd]};
    for (i_rd = 0; i_rd < 5; i_rd = i_rd + 1) begin
      if (paddr == `SIO_A_OUT_FUNC0 + 4 * i_rd) prdata = {16'h0000, out_func_q[i_rd]};
      if (paddr == `SIO_A_FORCE0 + 4 * i_rd) prdata = {16'h0000, force_q[i_rd]};
    end
    for (i_rd = 0; i_rd < 8; i_rd = i_rd + 1)
      if (paddr == `SIO_A_VIN_FUNC0 + 4 * i_rd) prdata = {16'h0000, vin_func_q[i_rd]};
    case (paddr)
      `SIO_A_POS_LO: prdata = {16'h0000, position_count[15:0]};
      `SIO_A_POS_HI: prdata = {16'h0000, position_count[31:16]};
      `SIO_A_VIN_CTRL: prdata = {30'h0, vin_ctrl_q};
      `SIO_A_VIN_STATE: prdata = {24'h0, vin_state_q};
      `SIO_A_VOUT_CTRL: prdata = {31'h0, vout_ctrl_q};
      `SIO_A_VOUT_STATE: prdata = {28'h0, vout_state_q};
      `SIO_A_TRQ_LEVEL: prdata = {16'h0000, trq_level_q};
      `SIO_A_TRQ_HYST: prdata = {16'h0000, trq_hyst_q};
      `SIO_A_TRQ_POL: prdata = {31'h0, trq_pol_q};
      `SIO_A_ZSP_THR: prdata = {16'h0000, zsp_thr_q};
      `SIO_A_BRK_DLY: prdata = {16'h0000, brk_dly_q};
      `SIO_A_ZPW: prdata = {16'h0000, zpw_q};
      `SIO_A_SER_FUNC: prdata = {31'h0, ser_func_q};
      `SIO_A_STATUS: prdata = {16'h0000, act_q, brake_release_out, zero_speed_out,
                               torque_arrival_out, enable_q};
      default: ;
    endcase
  end
endmodule

//--- sim/sio_host_model.sv
// host controller model driving the input terminals
`timescale 1ns/1ps
module sio_host_model (
  input wire pclk, // system clock
  input wire [3:0] want_active, // terminals the host asserts
  output reg [3:0] phys_input_n // terminal pins, active low
);
  initial phys_input_n = 4'hf;
  // idle terminals are driven high by the host; an asserted terminal is driven low
  always @(posedge pclk) begin
    phys_input_n <= ~want_active;
  end
endmodule

//--- sim/sio_term_mapper_asserts.sv
// port-level concurrent checks for the terminal mapper
`timescale 1ns/1ps
module sio_term_mapper_asserts (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire pready, // apb ready
  input wire [31:0] prdata, // read data
  input wire pslverr, // unmapped access
  input wire signed [15:0] motor_speed, // measured speed
  input wire index_event, // index pulse in
  input wire serial_port_enable, // serial port active
  input wire phys_output_5, // fifth output
  input wire drive_enable_in, // decoded enable
  input wire alarm_clear_in, // alarm clear pulse
  input wire zero_speed_out, // zero speed status
  input wire brake_release_out, // brake status
  input wire index_out // index output
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_access;
    psel && penable;
  endsequence
  sequence idx_seen;
    ##[1:2] index_out;
  endsequence
  ready_always_a: assert property (apb_access |-> pready)
    else $error("ready low in access phase");
  slverr_phase_a: assert property (pslverr |-> apb_access)
    else $error("error outside access phase");
  unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  serial_excl_a: assert property (serial_port_enable |-> !phys_output_5)
    else $error("fifth output active with serial port on");
  brake_enable_a: assert property (brake_release_out |-> drive_enable_in || $past(drive_enable_in))
    else $error("brake released without enable");
  alarm_pulse_a: assert property (alarm_clear_in |=> !alarm_clear_in)
    else $error("alarm clear longer than one cycle");
  zero_speed_a: assert property ($rose(zero_speed_out) |-> $past(motor_speed) < 16'sh03e8)
    else $error("zero speed raised at high speed");
  index_start_a: assert property (index_event |-> idx_seen)
    else $error("index output missing");
endmodule
bind sio_term_mapper sio_term_mapper_asserts chk_u (.*);

//--- sim/tb_top.sv
// self-checking bench for the terminal mapper
`timescale 1ns/1ps
`include "sio_term_map.vh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, index_event = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic signed [15:0] motor_torque = 16'sh0000, motor_speed = 16'sh0064;
  logic [31:0] position_count = 32'h0000_1234;
  logic [3:0] want_active = 4'h0;
  logic [7:0] od [5] = '{8'h02, 8'h03, 8'h05, 8'h08, 8'h12};
  wire pready, pslverr, phys_output_5, serial_port_enable, drive_enable_in, alarm_clear_in;
  wire torque_arrival_out, zero_speed_out, brake_release_out, index_out;
  wire [31:0] prdata;
  wire [3:0] phys_input_n, phys_output;
  int mismatches = 0, check_count = 0, cycles = 0, n, m;
  initial forever #2 pclk = ~pclk;
  sio_host_model host_u (.*);
  // short ms and us counts keep the delay scenarios brief
  sio_term_mapper #(.MS_CYCLES(10), .US_CYCLES(4)) dut_u (.*);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic pulse_idx;
    index_event <= 1'b1;
    @(posedge pclk);
    index_event <= 1'b0;
    n = 0;
    m = 0;
    repeat (30) begin
      @(posedge pclk);
      n += index_out;
      m += phys_output_5;
    end
  endtask
  task give_verdict;
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict;
    end
  end
  initial begin
    wt(10);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rchk("in func", 12'(4 * i), (i < 4) ? i + 1 : 0);
    for (int i = 0; i < 5; i++) rchk("out func", `SIO_A_OUT_FUNC0 + 12'(4 * i), od[i]);
    rchk("zero thr", `SIO_A_ZSP_THR, 32'h5);
    rchk("brake dly", `SIO_A_BRK_DLY, 32'h0);
    rchk("z width", `SIO_A_ZPW, 32'h32);
    rchk("serial sel", `SIO_A_SER_FUNC, 32'h0);
    chk("serial on", 1, serial_port_enable);
    apb(1'b1, 12'h100, 32'hffff);
    chk("wr refused", 1, err);
    rchk("unmapped", 12'h100, 32'h0);
    rchk("pos lo", `SIO_A_POS_LO, 32'h1234);
    rchk("pos hi", `SIO_A_POS_HI, 32'h0);
    apb(1'b1, `SIO_A_VIN_CTRL, 32'h3);
    rchk("vin clamp", `SIO_A_VIN_CTRL, 32'h2);
    apb(1'b1, `SIO_A_VIN_CTRL, 32'h0);
    want_active <= 4'h1;
    wt(6);
    chk("enable on", 1, drive_enable_in);
    want_active <= 4'h2;
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      n += alarm_clear_in;
    end
    chk("enable off", 0, drive_enable_in);
    chk("alarm pulses", 1, n);
    apb(1'b1, `SIO_A_IN_FUNC0, 32'h0);
    want_active <= 4'h1;
    wt(6);
    chk("null code", 0, drive_enable_in);
    apb(1'b1, `SIO_A_IN_FUNC0, 32'h1);
    apb(1'b1, `SIO_A_VIN_FUNC0, 32'h1);
    apb(1'b1, `SIO_A_VIN_CTRL, 32'h1);
    wt(6);
    chk("phys ignored", 0, drive_enable_in);
    apb(1'b1, `SIO_A_VIN_STATE, 32'h1);
    wt(6);
    chk("virtual on", 1, drive_enable_in);
    want_active <= 4'h0;
    apb(1'b1, `SIO_A_VIN_CTRL, 32'h0);
    wt(6);
    chk("virt ignored", 0, drive_enable_in);
    apb(1'b1, `SIO_A_FORCE0, 32'h1);
    wt(4);
    chk("forced on", 1, drive_enable_in);
    apb(1'b1, `SIO_A_FORCE0, 32'h0);
    apb(1'b1, `SIO_A_VIN_CTRL, 32'h2);
    wt(6);
    chk("combined", 1, drive_enable_in);
    apb(1'b1, `SIO_A_VIN_STATE, 32'h0);
    apb(1'b1, `SIO_A_BRK_DLY, 32'h2);
    want_active <= 4'h1;
    n = 0;
    while (drive_enable_in !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (brake_release_out !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("brake delay", 1, n >= 19 && n <= 21);
    want_active <= 4'h0;
    wt(6);
    chk("brake drop", 0, brake_release_out);
    motor_speed <= 16'sh0000;
    wt(4);
    chk("zero speed", 1, zero_speed_out);
    chk("out4 zsp", 1, phys_output[3]);
    motor_speed <= 16'sh0008;
    wt(4);
    chk("zsp hyst", 1, zero_speed_out);
    motor_speed <= 16'sh0014;
    wt(4);
    chk("zsp off", 0, zero_speed_out);
    motor_torque <= 16'sh0096;
    wt(4);
    chk("torque on", 1, torque_arrival_out);
    chk("out3 trq", 1, phys_output[2]);
    motor_torque <= 16'sh0062;
    wt(4);
    chk("trq hyst", 1, torque_arrival_out);
    motor_torque <= 16'sh005a;
    wt(4);
    chk("torque off", 0, torque_arrival_out);
    motor_torque <= -16'sh0096;
    wt(4);
    chk("trq any dir", 1, torque_arrival_out);
    apb(1'b1, `SIO_A_TRQ_POL, 32'h1);
    wt(4);
    chk("trq pos only", 0, torque_arrival_out);
    apb(1'b1, `SIO_A_ZPW, 32'h3);
    pulse_idx;
    chk("z width", 1, n >= 11 && n <= 13);
    chk("out5 quiet", 0, m);
    apb(1'b1, `SIO_A_SER_FUNC, 32'h1);
    wt(3);
    chk("serial off", 0, serial_port_enable);
    pulse_idx;
    chk("out5 diff", 1, m > 0);
    apb(1'b1, `SIO_A_VOUT_STATE, 32'h5);
    rchk("vout state", `SIO_A_VOUT_STATE, 32'h5);
    apb(1'b1, `SIO_A_VOUT_CTRL, 32'h1);
    wt(3);
    chk("virt out", 32'h5, phys_output);
    give_verdict;
  end
endmodule
